// >>> inc/adcrc_params.svh
// Purpose: named constants for the converter control block
// Assumes: 25 MHz reference clock
// Notes:   definitions only
`ifndef ADCRC_PARAMS_SVH
`define ADCRC_PARAMS_SVH
`define ADCRC_RES_W        12
`define ADCRC_BYTE_W       8
`define ADCRC_NIB_W        4
`define ADCRC_FULL_BITS    4'hC
`define ADCRC_SHORT_BITS   4'h8
`define ADCRC_STEP_NS      40
`define ADCRC_CLK_NS       40
`define ADCRC_STEP_CYC     ((`ADCRC_STEP_NS + `ADCRC_CLK_NS - 1) / `ADCRC_CLK_NS)
`define ADCRC_RES_RST      12'h000
`endif

// >>> inc/adcrc_pkg.sv
// Purpose: types for the converter control block
// Assumes: nothing
// Notes:   states gray coded along idle -> convert -> done
package adcrc_pkg;
    typedef enum logic [1:0]
    {
        ADCRC_IDLE = 2'h0,
        ADCRC_CONV = 2'h1,
        ADCRC_DONE = 2'h3
    } adcrc_state_type;
endpackage

// >>> design/adcrc_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: asynchronous inputs
// Notes:   first stage read only by the second
`timescale 1ns/10ps
module adcrc_sync
#(
    parameter int W = 1
)
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    // =====================================================
    // two flops per bit
    typedef struct packed
    {
        logic [W-1:0] s1;   // metastable stage
        logic [W-1:0] s2;   // clean stage
    } adcrc_sync_type;
    adcrc_sync_type st_reg;
    adcrc_sync_type st_next;

    // shift in
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = i_async;
        st_next.s2 = st_reg.s1;
    end

    // register
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.s2;
endmodule

// >>> design/adcrc_top.sv
// Purpose: control of a 12-bit successive-approximation converter
// Assumes: comparator result arrives on i_cmp_high, one decision per step
// Notes:   three-state data lines given as data plus per-bit enable
//
// Behaviour
// - act only with enable high, select low
// - selector low at start: twelve-bit conversion
// - selector high at start: eight-bit conversion
// - byte read, selector low: upper eight bits
// - byte read, selector high: low nibble, zeros
// - format pin chooses bytes or word
// - word read drives all twelve bits
// - byte lanes overlap onto one bus
// - busy rises when conversion begins
// - busy falls when conversion finishes
// - conversion uninterruptible, no output meanwhile
// - clear register, decide bits msb first
// - ignore convert commands while busy
// - standalone: falling read/convert starts conversion
`timescale 1ns/10ps
`include "adcrc_params.svh"
module adcrc_top
(
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_b,
    input  wire logic                     i_chip_enable,
    input  wire logic                     i_chip_select_b,
    input  wire logic                     i_read_convert,
    input  wire logic                     i_byte_length_select,
    input  wire logic                     i_word_format,
    input  wire logic                     i_cmp_high,
    output logic                          o_conversion_busy,
    output logic [`ADCRC_RES_W-1:0]       o_data,
    output logic [`ADCRC_RES_W-1:0]       o_data_oe
);
    // =====================================================
    // input synchronisers
    logic [5:0] sync_w;   // synced pins
    adcrc_sync #(.W(6)) u_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   ({i_chip_enable, i_chip_select_b, i_read_convert,
                     i_byte_length_select, i_word_format, i_cmp_high}),
        .o_sync    (sync_w)
    );
    logic ce_s;    // enable
    logic csb_s;   // select, active low
    logic rc_s;    // read high, convert low
    logic bls_s;   // byte/length selector
    logic wf_s;    // word format
    logic cmp_s;   // comparator says keep bit
    assign {ce_s, csb_s, rc_s, bls_s, wf_s, cmp_s} = sync_w;

    // =====================================================
    // state
    typedef struct packed
    {
        adcrc_pkg::adcrc_state_type st;    // sequencer state
        logic [`ADCRC_RES_W-1:0]    approximation_register;   // approximation register
        logic [`ADCRC_RES_W-1:0]    res;   // held result
        logic [3:0]                 idx;   // bits left
        logic [3:0]                 stop;  // bits remaining at end
        logic [7:0]                 step;  // step timer
        logic                       act_q; // previous convert command
        logic                       busy;  // status pin
        logic [`ADCRC_RES_W-1:0]    dout;  // data pins
        logic [`ADCRC_RES_W-1:0]    doe;   // data pin enables
    } adcrc_top_type;
    adcrc_top_type s_reg;
    adcrc_top_type s_next;

    localparam logic [7:0] STEP_CYC = 8'(`ADCRC_STEP_CYC);   // cycles per bit
    localparam int         LANE_TOP = `ADCRC_RES_W - 1;      // highest data lane
    localparam int         LANE_LOW = `ADCRC_NIB_W;          // lowest lane of the byte window

    logic sel_w;   // device selected
    logic cnv_w;   // convert command level
    logic rd_w;    // read command level
    assign sel_w = ce_s && !csb_s;
    assign cnv_w = sel_w && !rc_s;
    assign rd_w  = sel_w && rc_s;

    // =====================================================
    // next-state logic
    always_comb
    begin
        s_next       = s_reg;
        s_next.act_q = cnv_w;
        unique case (s_reg.st)
            adcrc_pkg::ADCRC_IDLE:
            begin
                // start on the rising edge of the convert level (read/convert falling); covers
                // both full-control and standalone wiring
                if (cnv_w && !s_reg.act_q)
                begin
                    s_next.st   = adcrc_pkg::ADCRC_CONV;
                    s_next.approximation_register  = `ADCRC_RES_RST;
                    s_next.idx  = `ADCRC_FULL_BITS;
                    s_next.stop = bls_s ? (`ADCRC_FULL_BITS - `ADCRC_SHORT_BITS)
                                        : 4'h0;
                    s_next.step = 8'h00;
                    s_next.busy = 1'b1;
                end
            end
            adcrc_pkg::ADCRC_CONV:
            begin
                // further commands ignored, no way out but completion
                if (s_reg.step == STEP_CYC - 8'h01)
                begin
                    s_next.step = 8'h00;
                    // trial bit decided msb first
                    s_next.approximation_register[s_reg.idx - 4'h1] = cmp_s;
                    s_next.idx = s_reg.idx - 4'h1;
                    if (s_reg.idx - 4'h1 == s_reg.stop)
                    begin
                        s_next.st = adcrc_pkg::ADCRC_DONE;
                    end
                end
                else
                begin
                    s_next.step = s_reg.step + 8'h01;
                end
            end
            adcrc_pkg::ADCRC_DONE:
            begin
                // latch result and release status in the same cycle
                s_next.res  = s_reg.approximation_register;
                s_next.busy = 1'b0;
                s_next.st   = adcrc_pkg::ADCRC_IDLE;
            end
            default:
            begin
                s_next.st = adcrc_pkg::ADCRC_IDLE;
            end
        endcase

        // output buffers: never during a conversion
        s_next.dout = '0;
        s_next.doe  = '0;
        if (rd_w && !s_next.busy && !s_reg.busy)
        begin
            if (wf_s)
            begin
                s_next.dout = s_next.res;
                s_next.doe  = '1;
            end
            else if (!bls_s)
            begin
                // upper byte lanes: top eight bits
                s_next.dout[LANE_TOP:LANE_LOW] = s_next.res[LANE_TOP:LANE_LOW];
                s_next.doe[LANE_TOP:LANE_LOW]  = '1;
            end
            else
            begin
                // low nibble left-justified on the same lanes, zeros below
                s_next.dout[LANE_TOP:LANE_LOW] = {s_next.res[LANE_LOW-1:0],
                                                  {`ADCRC_NIB_W{1'b0}}};
                s_next.doe[LANE_TOP:LANE_LOW]  = '1;
            end
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_reg     <= '0;
            s_reg.st  <= adcrc_pkg::ADCRC_IDLE;
            s_reg.res <= `ADCRC_RES_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_conversion_busy = s_reg.busy;
    assign o_data            = s_reg.dout;
    assign o_data_oe         = s_reg.doe;

    // =====================================================
    // assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    busy_rise_a: assert property (
        (s_reg.st == adcrc_pkg::ADCRC_IDLE && cnv_w && !s_reg.act_q) |=> o_conversion_busy)
        else $error("busy did not rise");
    busy_fall_a: assert property (
        s_reg.st == adcrc_pkg::ADCRC_DONE |=> !o_conversion_busy)
        else $error("busy did not fall");
    no_out_busy_a: assert property (
        o_conversion_busy |-> o_data_oe == '0)
        else $error("output driven during conversion");
    sar_clear_a: assert property (
        $rose(o_conversion_busy) |-> s_reg.approximation_register == '0)
        else $error("register not cleared");
    // bits below the trial position are still clear, so decisions run msb first
    sar_order_a: assert property (
        s_reg.st == adcrc_pkg::ADCRC_CONV
        |-> (s_reg.approximation_register & ~({`ADCRC_RES_W{1'b1}} << s_reg.idx)) == '0)
        else $error("bits decided out of order");
    // a restart would push the bit index back up
    ignore_cmd_a: assert property (
        s_reg.st != adcrc_pkg::ADCRC_IDLE |=> s_reg.idx <= $past(s_reg.idx))
        else $error("conversion restarted");
    unsel_idle_a: assert property (
        (!sel_w && s_reg.st == adcrc_pkg::ADCRC_IDLE)
        |=> s_reg.st == adcrc_pkg::ADCRC_IDLE && o_data_oe == '0)
        else $error("acted while deselected");
    word_read_a: assert property (
        (rd_w && wf_s && !o_conversion_busy && s_reg.st == adcrc_pkg::ADCRC_IDLE)
        |=> o_data_oe == '1 && o_data == s_reg.res)
        else $error("word read not full");
    high_byte_a: assert property (
        (rd_w && !wf_s && !bls_s && s_reg.st == adcrc_pkg::ADCRC_IDLE)
        |=> o_data == {s_reg.res[LANE_TOP:LANE_LOW], {`ADCRC_NIB_W{1'b0}}}
            && o_data_oe == {{`ADCRC_BYTE_W{1'b1}}, {`ADCRC_NIB_W{1'b0}}})
        else $error("upper byte wrong");
    low_byte_a: assert property (
        (rd_w && !wf_s && bls_s && s_reg.st == adcrc_pkg::ADCRC_IDLE)
        |=> o_data == {s_reg.res[LANE_LOW-1:0], {`ADCRC_BYTE_W{1'b0}}}
            && o_data_oe == {{`ADCRC_BYTE_W{1'b1}}, {`ADCRC_NIB_W{1'b0}}})
        else $error("byte lane wrong");
    hold_res_a: assert property (
        s_reg.st != adcrc_pkg::ADCRC_DONE |=> $stable(s_reg.res))
        else $error("result changed");
    full_stop_a: assert property (
        (s_reg.st == adcrc_pkg::ADCRC_IDLE && cnv_w && !s_reg.act_q && !bls_s)
        |=> s_reg.stop == 4'h0)
        else $error("full length not chosen");
    short_stop_a: assert property (
        (s_reg.st == adcrc_pkg::ADCRC_IDLE && cnv_w && !s_reg.act_q && bls_s)
        |=> s_reg.stop == `ADCRC_FULL_BITS - `ADCRC_SHORT_BITS)
        else $error("bad length");

    conv_c: cover property ($fell(o_conversion_busy));
    word_c: cover property (o_data_oe == 12'hFFF);
    byte_c: cover property (o_data_oe == 12'hFF0);
    // fresh convert command while a conversion runs
    retrig_c: cover property (s_reg.st == adcrc_pkg::ADCRC_CONV && cnv_w && !s_reg.act_q);
endmodule

// >>> verification/adcrc_host_model.sv
// Purpose: far-side model: comparator decision and a pulled-up 8/12-bit data bus
// Assumes: lanes that no one drives read high through bus pull-ups
// Notes:   comparator level is held steady for a whole conversion
`timescale 1ns/10ps
module adcrc_host_model
(
    input  wire logic        i_cmp_level,
    input  wire logic [11:0] i_data,
    input  wire logic [11:0] i_data_oe,
    output logic             o_cmp_high,
    output logic [11:0]      o_bus
);
    // ==========================================
    // comparator: one steady answer, so the result is known without timing guesses
    assign o_cmp_high = i_cmp_level;
    // ==========================================
    // bus resolve: released lanes float to the pull-up, never to the last value
    always_comb
    begin
        for (int i = 0; i < 12; i++)
            o_bus[i] = i_data_oe[i] ? i_data[i] : 1'b1;
    end
endmodule

// >>> verification/tb_adc_conversion_read_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: 25 MHz clock, pins driven by non-blocking assignment at rising edges
// Notes:   comparator held at one level per conversion, so decided bits are all ones or all zeros
`timescale 1ns/10ps
module tb_adc_conversion_read_control;
    logic        clk;        // reference clock
    logic        rst_b;      // async reset, active low
    logic        ce;         // chip enable
    logic        cs_b;       // chip select, active low
    logic        rc;         // read high, convert low
    logic        sel;        // byte/length selector
    logic        wf;         // word format
    logic        cmp_level;  // comparator level chosen per conversion
    logic        cmp;        // comparator into the block
    logic        busy;       // conversion busy
    logic [11:0] data;       // result lanes
    logic [11:0] oe;         // lane drive enables
    logic [11:0] bus;        // resolved bus with pull-ups
    int          err_total;  // mismatches
    int          n_checks;   // comparisons
    int          n;          // busy length
    // ==========================================
    // clock and design under test
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    adcrc_top DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_chip_enable(ce),
        .i_chip_select_b(cs_b), .i_read_convert(rc), .i_byte_length_select(sel),
        .i_word_format(wf), .i_cmp_high(cmp), .o_conversion_busy(busy),
        .o_data(data), .o_data_oe(oe));
    adcrc_host_model host (.i_cmp_level(cmp_level), .i_data(data), .i_data_oe(oe),
        .o_cmp_high(cmp), .o_bus(bus));
    // ==========================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // convert: fall of the command, count busy cycles; poke = read and re-fall mid-run
    task automatic convert(input logic s, input logic lvl, input logic poke, output int cnt);
        int w;
        cnt = 0;
        w = 0;
        ce <= 1'b1;
        cs_b <= 1'b0;
        rc <= 1'b0;
        sel <= s;
        cmp_level <= lvl;
        while (busy !== 1'b1 && w < 10)
        begin
            tick(1);
            #1 w++;
        end
        if (busy !== 1'b1)
        begin
            err_total++;
            report_and_stop();
        end
        chk(12'(w), 12'h003);
        while (busy === 1'b1 && cnt < 40)
        begin
            tick(1);
            if (poke && cnt == 3)
                rc <= 1'b1;
            if (poke && cnt == 7)
                rc <= 1'b0;
            #1 cnt++;
            if (poke && cnt == 7)
                chk(oe, 12'h000);
        end
        tick(2);
        cs_b <= 1'b1;
        rc <= 1'b1;
        tick(4);
    endtask
    // read: hold the read command, sample lanes once the lag has passed
    task automatic rd(input logic f, input logic s, input logic [11:0] ed, input logic [11:0] eo);
        cs_b <= 1'b0;
        ce <= 1'b1;
        rc <= 1'b1;
        wf <= f;
        sel <= s;
        tick(5);
        #1 chk(data & oe, ed);
        chk(oe, eo);
        chk(bus, ed | ~eo);
        tick(1);
        cs_b <= 1'b1;
        tick(4);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {ce, sel, cmp_level, rst_b} = 4'h0;
        {cs_b, rc, wf} = 3'h7;
        err_total = 0;
        n_checks = 0;
        tick(10);
        rst_b <= 1'b1;
        tick(2);
        #1 chk({11'h000, busy}, 12'h000);
        chk(oe, 12'h000);
        // no action unless enabled and selected together
        tick(1);
        cs_b <= 1'b0;
        rc <= 1'b0;
        tick(6);
        ce <= 1'b1;
        cs_b <= 1'b1;
        tick(6);
        #1 chk({11'h000, busy}, 12'h000);
        tick(1);
        rc <= 1'b1;
        tick(4);
        $display("test idle done");
        convert(1'b0, 1'b1, 1'b0, n);
        chk(12'(n), 12'h00D);
        rd(1'b1, 1'b0, 12'hFFF, 12'hFFF);
        rd(1'b0, 1'b0, 12'hFF0, 12'hFF0);
        rd(1'b0, 1'b1, 12'hF00, 12'hFF0);
        $display("test full length done");
        convert(1'b1, 1'b1, 1'b0, n);
        chk(12'(n), 12'h009);
        rd(1'b1, 1'b1, 12'hFF0, 12'hFFF);
        rd(1'b0, 1'b1, 12'h000, 12'hFF0);
        $display("test short length done");
        convert(1'b0, 1'b0, 1'b1, n);
        chk(12'(n), 12'h00D);
        rd(1'b1, 1'b0, 12'h000, 12'hFFF);
        rd(1'b1, 1'b0, 12'h000, 12'hFFF);
        $display("test busy retrigger done");
        // standalone: selected and reading, then the command falls
        cs_b <= 1'b0;
        wf <= 1'b1;
        sel <= 1'b0;
        tick(5);
        convert(1'b0, 1'b1, 1'b0, n);
        chk(12'(n), 12'h00D);
        rd(1'b1, 1'b0, 12'hFFF, 12'hFFF);
        $display("test standalone done");
        report_and_stop();
    end
endmodule
